// ==== hw/tweep_device.sv ====
`timescale 1ns/1ps
`include "tweep_cfg.svh"
module tweep_device #(
    parameter logic [3:0] DEV_TYPE = `TWEEP_DEV_TYPE, // arbitrary type code
    parameter int PROG_CYCLES = `TWEEP_PROG_CYCLES,
    parameter int ADDR_W = `TWEEP_ADDR_W,
    parameter int PAGE_W = `TWEEP_PAGE_W
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    tweep_if.dev bus,
    input wire logic chip_select_bit_zero_in,
    input wire logic chip_select_bit_one_in,
    input wire logic chip_select_bit_two_in,
    input wire logic write_protect_in,
    output logic busy_out,
    output logic standby_out
);

    localparam int MEM_BYTES = 1 << ADDR_W; // whole array
    localparam int PAGE_BYTES = 1 << PAGE_W; // one page
    localparam int HI_W = ADDR_W - 8; // bits in first address byte
    localparam int PC_W = $clog2(PROG_CYCLES + 1); // programming counter width
    localparam logic [PC_W-1:0] PROG_LAST = PC_W'(PROG_CYCLES - 1);
    localparam logic [PC_W-1:0] PAGE_END = PC_W'(PAGE_BYTES);
    logic [5:0] pin_meta; // first synchroniser stage
    logic [5:0] pin_sync; // second synchroniser stage
    logic scl_prev; // clock one cycle back
    logic sda_prev; // data one cycle back
    tweep_pkg::tweep_dev_state_t state; // bus state
    logic [3:0] cnt; // bit counter within byte
    logic [1:0] byte_num; // 0 slave addr, 1 addr hi, 2 addr lo, 3 data
    logic [7:0] shreg; // received byte
    logic [7:0] out_byte; // byte being sent
    logic rw; // direction of the current transfer
    logic [HI_W-1:0] addr_hi; // held first address byte
    logic [ADDR_W-1:0] ptr; // internal address counter
    logic [PAGE_BYTES-1:0] page_mask; // page bytes received
    logic have_data; // write transfer carries data
    logic sda_low; // pull data line low
    logic prog_busy; // programming cycle running
    logic [PC_W-1:0] prog_cnt; // programming timer
    logic [7:0] mem [MEM_BYTES]; // the array
    logic [7:0] page_buf [PAGE_BYTES]; // page latch
    // raw pins, idle lines read high
    wire [5:0] pin_raw = {write_protect_in, chip_select_bit_two_in, chip_select_bit_one_in,
                          chip_select_bit_zero_in, bus.sda, bus.scl};

    // two flops on every pin, then one more for edges
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pin_meta <= 6'h03;
            pin_sync <= 6'h03;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            scl_prev <= pin_sync[0];
            sda_prev <= pin_sync[1];
        end
    end

    wire scl = pin_sync[0]; // synced clock
    wire sda = pin_sync[1]; // synced data
    wire [2:0] cs = pin_sync[4:2]; // synced chip selects
    wire wp = pin_sync[5]; // synced write protect
    wire scl_rise = scl & ~scl_prev; // clock rising edge
    wire scl_fall = ~scl & scl_prev; // clock falling edge
    // data falling with clock high throughout
    wire start_seen = scl & scl_prev & sda_prev & ~sda;
    // data rising with clock high throughout
    wire stop_seen = scl & scl_prev & ~sda_prev & sda;
    // eighth bit completed at the falling clock
    wire byte_done = scl_fall & (cnt == 4'h8);
    // type nibble, chip selects, idle array
    wire addr_match = (shreg[7:4] == DEV_TYPE) & (shreg[3:1] == cs) & ~prog_busy;
    wire data_done = (state == tweep_pkg::DEV_RECV) & byte_done & (byte_num == 2'h3);
    wire [7:0] rd_byte = mem[ptr]; // byte at address counter
    // in-page increment, page bits held
    wire [ADDR_W-1:0] ptr_page_inc = {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 1'b1};
    wire [ADDR_W-1:0] ptr_lin_inc = ptr + 1'b1; // read rolls over the array
    wire [1:0] byte_num_inc = (byte_num == 2'h3) ? 2'h3 : byte_num + 2'h1;
    wire prog_go = stop_seen & have_data & ~wp & ~prog_busy;
    wire prog_write = prog_busy & (prog_cnt < PAGE_END); // first cycles copy the page
    wire [PAGE_W-1:0] prog_idx = prog_cnt[PAGE_W-1:0];
    wire prog_last = prog_busy & (prog_cnt == PROG_LAST);

    // bus state machine, start and stop win over bit activity
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            // power-on reset: standby, nothing pending
            state <= tweep_pkg::DEV_IDLE;
            cnt <= 4'h0;
            byte_num <= 2'h0;
            shreg <= 8'h00;
            out_byte <= 8'h00;
            rw <= 1'b0;
            addr_hi <= '0;
            ptr <= '0;
            page_mask <= '0;
            have_data <= 1'b0;
            sda_low <= 1'b0;
        end
        else if (start_seen)
        begin
            // new command, partial data of an unstopped write dropped
            state <= tweep_pkg::DEV_RECV;
            cnt <= 4'h0;
            byte_num <= 2'h0;
            sda_low <= 1'b0;
            have_data <= 1'b0;
            if (!prog_busy) page_mask <= '0;
        end
        else if (stop_seen)
        begin
            // back to standby, programming runs on if started
            state <= tweep_pkg::DEV_IDLE;
            sda_low <= 1'b0;
            have_data <= 1'b0;
        end
        else
        begin
            unique case (state)
                // bus activity ignored until start
                tweep_pkg::DEV_IDLE: sda_low <= 1'b0;
                tweep_pkg::DEV_RECV:
                begin
                    if (scl_rise)
                    begin
                        // sample data while clock high, msb first
                        shreg <= {shreg[6:0], sda};
                        cnt <= cnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        cnt <= 4'h0;
                        if (byte_num == 2'h0)
                        begin
                            if (addr_match)
                            begin
                                // pull low through the ninth pulse
                                rw <= shreg[0];
                                sda_low <= 1'b1;
                                state <= tweep_pkg::DEV_ACK;
                            end
                            else
                                state <= tweep_pkg::DEV_IDLE;
                        end
                        else
                        begin
                            sda_low <= 1'b1;
                            state <= tweep_pkg::DEV_ACK;
                            if (byte_num == 2'h1) addr_hi <= shreg[HI_W-1:0];
                            else if (byte_num == 2'h2) ptr <= {addr_hi, shreg};
                            else
                            begin
                                // any count of data bytes, overflow overwrites
                                page_mask[ptr[PAGE_W-1:0]] <= 1'b1;
                                have_data <= 1'b1;
                                ptr <= ptr_page_inc;
                            end
                        end
                    end
                end
                tweep_pkg::DEV_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rw)
                        begin
                            // first bit of read byte goes out on the low clock
                            state <= tweep_pkg::DEV_SEND;
                            out_byte <= rd_byte;
                            ptr <= ptr_lin_inc;
                            sda_low <= ~rd_byte[7];
                            cnt <= 4'h1;
                        end
                        else
                        begin
                            state <= tweep_pkg::DEV_RECV;
                            sda_low <= 1'b0;
                            byte_num <= byte_num_inc;
                        end
                    end
                end
                tweep_pkg::DEV_SEND:
                begin
                    if (scl_fall)
                    begin
                        if (cnt == 4'h8)
                        begin
                            // release for master acknowledge
                            state <= tweep_pkg::DEV_MACK;
                            sda_low <= 1'b0;
                        end
                        else
                        begin
                            sda_low <= ~out_byte[~cnt[2:0]];
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                tweep_pkg::DEV_MACK:
                begin
                    // low: send next byte, high: back to standby at once
                    if (scl_rise) state <= sda ? tweep_pkg::DEV_IDLE : tweep_pkg::DEV_ACK;
                end
            endcase
        end
    end

    // self-timed programming timer
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prog_busy <= 1'b0;
            prog_cnt <= '0;
        end
        else if (prog_go)
        begin
            prog_busy <= 1'b1;
            prog_cnt <= '0;
        end
        else if (prog_busy)
        begin
            prog_busy <= ~prog_last;
            prog_cnt <= prog_cnt + 1'b1;
        end
    end

    // page latch fills per data byte, only received bytes are programmed
    always_ff @(posedge clk_in)
    begin
        if (data_done) page_buf[ptr[PAGE_W-1:0]] <= shreg;
        if (prog_write && page_mask[prog_idx])
            mem[{ptr[ADDR_W-1:PAGE_W], prog_idx}] <= page_buf[prog_idx];
    end

    // open-drain: drive value fixed low, enable only
    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_sda_oe_n = ~sda_low;
    assign busy_out = prog_busy;
    assign standby_out = (state == tweep_pkg::DEV_IDLE) & ~prog_busy;
endmodule : tweep_device

// ==== inc/tweep_cfg.svh ====
`ifndef TWEEP_CFG_SVH
`define TWEEP_CFG_SVH

// system clock period in ns
`define TWEEP_CLK_NS 20
// array address width: 8192 bytes
`define TWEEP_ADDR_W 13
// in-page offset width: 32-byte pages
`define TWEEP_PAGE_W 5
// fixed device-type nibble of the slave address (value arbitrary)
`define TWEEP_DEV_TYPE 4'h5
// longest self-timed programming time in ms
`define TWEEP_PROG_TIME_MS 5
// programming time in clock cycles, rounded down
`define TWEEP_PROG_CYCLES ((`TWEEP_PROG_TIME_MS * 1000000) / `TWEEP_CLK_NS)
// least quarter period of the serial clock in ns (1 MHz bus)
`define TWEEP_SCL_QUARTER_NS 250
// quarter period in clock cycles, rounded up
`define TWEEP_SCL_QUARTER_CYCLES ((`TWEEP_SCL_QUARTER_NS + `TWEEP_CLK_NS - 1) / `TWEEP_CLK_NS)

`endif

// ==== inc/tweep_pkg.sv ====
package tweep_pkg;

    // device-side bus states
    typedef enum logic [4:0] {
        DEV_IDLE = 5'h01,
        DEV_RECV = 5'h02,
        DEV_ACK  = 5'h04,
        DEV_SEND = 5'h08,
        DEV_MACK = 5'h10
    } tweep_dev_state_t;

    // host engine states
    typedef enum logic [3:0] {
        HOST_IDLE  = 4'h1,
        HOST_START = 4'h2,
        HOST_STOP  = 4'h4,
        HOST_BIT   = 4'h8
    } tweep_host_state_t;

    // host command codes
    typedef enum logic [1:0] {
        CMD_START = 2'h0,
        CMD_STOP  = 2'h1,
        CMD_WRITE = 2'h2,
        CMD_READ  = 2'h3
    } tweep_cmd_t;

endpackage : tweep_pkg

// ==== inc/tweep_if.sv ====
`timescale 1ns/1ps

interface tweep_if;
    logic scl; // serial clock, made by the host
    logic host_sda_out; // host data drive value, always low
    logic host_sda_oe_n; // host pulls data low while this is low
    logic dev_sda_out; // device data drive value, always low
    logic dev_sda_oe_n; // device pulls data low while this is low
    logic sda; // resolved wired-and data line with pull-up

    // wired-and of both open-drain drivers, released line reads high
    assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

    modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
    modport host (output scl, output host_sda_out, output host_sda_oe_n, input sda);
endinterface : tweep_if

// ==== hw/tweep_host.sv ====
`timescale 1ns/1ps
`include "tweep_cfg.svh"

module tweep_host #(
    parameter int QUARTER = `TWEEP_SCL_QUARTER_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    tweep_if.host bus,
    input wire logic cmd_valid_in,
    input wire tweep_pkg::tweep_cmd_t cmd_kind_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic cmd_ack_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic [7:0] rd_data_out,
    output logic ack_seen_out
);

    localparam int Q_W = $clog2(QUARTER + 1); // quarter timer width
    localparam logic [Q_W-1:0] Q_LAST = Q_W'(QUARTER - 1);

    tweep_pkg::tweep_host_state_t state; // engine state
    logic [Q_W-1:0] tick_cnt; // quarter timer
    logic [1:0] phase; // quarter within step
    logic [3:0] bit_cnt; // bit within byte, 8 is acknowledge
    logic [7:0] shreg; // data out / in
    logic is_read; // current byte is a read
    logic ack_flag; // acknowledge a read byte
    logic scl_drv; // serial clock level
    logic sda_low; // pull data low
    logic sda_meta; // first synchroniser stage
    logic sda_sync; // second synchroniser stage

    wire tick = (state != tweep_pkg::HOST_IDLE) & (tick_cnt == Q_LAST);
    wire accept = (state == tweep_pkg::HOST_IDLE) & cmd_valid_in;
    wire last_bit = (bit_cnt == 4'h8);
    // read: release then acknowledge, write: data then release
    wire drive_bit = last_bit ? (is_read & ack_flag) : (~is_read & ~shreg[7]);

    // data line sampled through two flops
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end
        else
        begin
            sda_meta <= bus.sda;
            sda_sync <= sda_meta;
        end
    end

    // quarter-period divider for the serial clock
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= (accept | tick) ? '0 : tick_cnt + 1'b1;
        end
    end

    // bus engine, one step per quarter
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state <= tweep_pkg::HOST_IDLE;
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            is_read <= 1'b0;
            ack_flag <= 1'b0;
            scl_drv <= 1'b1;
            sda_low <= 1'b0;
            done_out <= 1'b0;
            rd_data_out <= 8'h00;
            ack_seen_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (accept)
            begin
                phase <= 2'h0;
                bit_cnt <= 4'h0;
                shreg <= cmd_data_in;
                is_read <= (cmd_kind_in == tweep_pkg::CMD_READ);
                ack_flag <= cmd_ack_in;
                unique case (cmd_kind_in)
                    tweep_pkg::CMD_START: state <= tweep_pkg::HOST_START;
                    tweep_pkg::CMD_STOP: state <= tweep_pkg::HOST_STOP;
                    tweep_pkg::CMD_WRITE, tweep_pkg::CMD_READ: state <= tweep_pkg::HOST_BIT;
                endcase
            end
            else if (tick)
            begin
                phase <= phase + 2'h1;
                unique case (state)
                    tweep_pkg::HOST_START:
                    begin
                        // release, clock high, data falls, clock low
                        if (phase == 2'h0) sda_low <= 1'b0;
                        if (phase == 2'h1) scl_drv <= 1'b1;
                        if (phase == 2'h2) sda_low <= 1'b1;
                        if (phase == 2'h3) scl_drv <= 1'b0;
                    end
                    tweep_pkg::HOST_STOP:
                    begin
                        // data low, clock high, data rises
                        if (phase == 2'h0) sda_low <= 1'b1;
                        if (phase == 2'h1) scl_drv <= 1'b1;
                        if (phase == 2'h2) sda_low <= 1'b0;
                    end
                    tweep_pkg::HOST_BIT:
                    begin
                        // data set on low clock, held over the high half
                        if (phase == 2'h0) sda_low <= drive_bit;
                        if (phase == 2'h1) scl_drv <= 1'b1;
                        if (phase == 2'h3)
                        begin
                            scl_drv <= 1'b0;
                            if (last_bit)
                            begin
                                rd_data_out <= shreg;
                                ack_seen_out <= ~sda_sync;
                            end
                            else
                            begin
                                shreg <= {shreg[6:0], sda_sync};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    tweep_pkg::HOST_IDLE:
                    begin
                        sda_low <= sda_low;
                    end
                endcase
                if (phase == 2'h3 && (state != tweep_pkg::HOST_BIT || last_bit))
                begin
                    state <= tweep_pkg::HOST_IDLE;
                    done_out <= 1'b1;
                end
            end
        end
    end

    assign cmd_ready_out = (state == tweep_pkg::HOST_IDLE);
    assign bus.scl = scl_drv;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe_n = ~sda_low;

endmodule : tweep_host

// ==== tb/tweep_properties.sv ====
`timescale 1ns/1ps

module tweep_properties #(
    parameter int PROG = 400
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n,
    input wire logic write_protect_in,
    input wire logic busy_out,
    input wire logic standby_out
);
    int cnt; // programming cycles so far
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // count cycles while programming
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cnt <= 0;
        else
            cnt <= busy_out ? cnt + 1 : 0;
    end
    a_drive_low_only: assert property (dev_sda_out == 1'h0)
        else $error("device drives data high");
    a_standby_released: assert property (standby_out |-> dev_sda_oe_n)
        else $error("device pulls data in standby");
    a_no_ack_busy: assert property (busy_out |-> dev_sda_oe_n)
        else $error("device pulls data while programming");
    a_busy_not_standby: assert property (busy_out |-> !standby_out)
        else $error("standby while programming");
    a_prog_bound: assert property (busy_out |-> cnt < PROG)
        else $error("programming too long");
    a_prog_exact: assert property ($fell(busy_out) |-> cnt == PROG)
        else $error("programming length wrong");
    a_change_clock_low: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
        else $error("device data changed with clock high");
    a_reset_standby: assert property ($rose(reset_n_in) |-> standby_out && !busy_out)
        else $error("not standby after reset");
    a_prog_after_stop: assert property ($rose(busy_out) |-> scl && sda && !write_protect_in)
        else $error("programming without stop or under protect");
    c_prog: cover property ($rose(busy_out));
    c_ack: cover property (!dev_sda_oe_n && scl);
    c_standby: cover property ($rose(standby_out));
endmodule : tweep_properties

// ==== tb/test_two_wire_serial_eeprom_slave.sv ====
`timescale 1ns/1ps
`include "tweep_cfg.svh"

module test_two_wire_serial_eeprom_slave;
    localparam logic [3:0] DT = `TWEEP_DEV_TYPE; // device-type nibble
    logic clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic [2:0] cs = 3'h0; // chip-select straps
    logic wp = 1'h0; // write protect
    logic cmd_valid = 1'h0;
    tweep_pkg::tweep_cmd_t cmd_kind = tweep_pkg::CMD_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ack = 1'h0;
    logic cmd_ready, done, ack_seen, busy, standby;
    logic [7:0] rd_data;
    logic [8:0] bits = 9'h000; // last nine wire bits
    int failures = 0;
    int cmp_count = 0;
    tweep_if bus ();
    tweep_device #(.PROG_CYCLES(400)) i_tweep_device (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus(bus.dev),
        .chip_select_bit_zero_in(cs[0]), .chip_select_bit_one_in(cs[1]), .chip_select_bit_two_in(cs[2]),
        .write_protect_in(wp), .busy_out(busy), .standby_out(standby));
    tweep_host #(.QUARTER(8)) i_tweep_host (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus(bus.host),
        .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind), .cmd_data_in(cmd_data), .cmd_ack_in(cmd_ack),
        .cmd_ready_out(cmd_ready), .done_out(done), .rd_data_out(rd_data), .ack_seen_out(ack_seen));
    tweep_properties #(.PROG(400)) i_tweep_properties (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl(bus.scl),
        .sda(bus.sda), .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n), .write_protect_in(wp),
        .busy_out(busy), .standby_out(standby));
    // 50 MHz clock
    always #10 clk_in = ~clk_in;
    // wire bits, msb first, ninth is acknowledge
    always @(posedge bus.scl) bits <= {bits[7:0], bus.sda};
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one host command, waits for its end
    task automatic cmd(input tweep_pkg::tweep_cmd_t kind, input logic [7:0] data, input logic ack);
        int n;
        @(negedge clk_in);
        cmd_kind = kind;
        {cmd_valid, cmd_data, cmd_ack} = {1'h1, data, ack};
        @(negedge clk_in);
        cmd_valid = 1'h0;
        check("taken", {8'h00, cmd_ready}, 9'h000);
        n = 0;
        while (done !== 1'h1 && n < 1000)
        begin
            @(negedge clk_in);
            n++;
        end
        check("done", {7'h00, done, cmd_ready}, 9'h003);
    endtask : cmd
    task automatic wr(input logic [7:0] d, input logic a);
        cmd(tweep_pkg::CMD_WRITE, d, 1'h0);
        check("ack", {8'h00, ack_seen}, {8'h00, a});
        check("wbits", bits, {d, ~a});
    endtask : wr
    task automatic rd(input logic [7:0] exp, input logic a);
        cmd(tweep_pkg::CMD_READ, 8'h00, a);
        check("rdata", {1'h0, rd_data}, {1'h0, exp});
        check("rbits", bits, {exp, ~a});
    endtask : rd
    task automatic sel(input logic [7:0] slave, input logic a);
        cmd(tweep_pkg::CMD_START, 8'h00, 1'h0);
        check("start", {7'h00, bus.scl, bus.sda}, 9'h000);
        wr(slave, a);
    endtask : sel
    task automatic stop();
        cmd(tweep_pkg::CMD_STOP, 8'h00, 1'h0);
        check("stop", {7'h00, bus.scl, bus.sda}, 9'h003);
    endtask : stop
    // random read of one byte
    task automatic rdat(input logic [15:0] addr, input logic [7:0] exp);
        sel({DT, 3'h0, 1'h0}, 1'h1);
        wr(addr[15:8], 1'h1);
        wr(addr[7:0], 1'h1);
        sel({DT, 3'h0, 1'h1}, 1'h1);
        rd(exp, 1'h0);
        stop();
    endtask : rdat
    task automatic test_reset();
        check("idle", {5'h00, standby, busy, bus.scl, bus.sda}, 9'h00B);
        $display("test_reset done");
    endtask : test_reset
    // three bytes from offset 30 wrap in the page
    task automatic test_page_write();
        int n;
        sel({DT, 3'h0, 1'h0}, 1'h1);
        wr(8'h0A, 1'h1);
        wr(8'h5E, 1'h1);
        wr(8'hA1, 1'h1);
        wr(8'hB2, 1'h1);
        wr(8'hC3, 1'h1);
        stop();
        check("busy", {8'h00, busy}, 9'h001);
        sel({DT, 3'h0, 1'h0}, 1'h0);
        stop();
        n = 0;
        while (busy !== 1'h0 && n < 500)
        begin
            @(negedge clk_in);
            n++;
        end
        check("ready", {7'h00, busy, standby}, 9'h001);
        sel({DT, 3'h0, 1'h0}, 1'h1);
        wr(8'h0A, 1'h1);
        wr(8'h5E, 1'h1);
        sel({DT, 3'h0, 1'h1}, 1'h1);
        rd(8'hA1, 1'h1);
        rd(8'hB2, 1'h0);
        stop();
        rdat(16'h0A40, 8'hC3);
        $display("test_page_write done");
    endtask : test_page_write
    task automatic test_protect();
        wp = 1'h1;
        sel({DT, 3'h0, 1'h0}, 1'h1);
        wr(8'h0A, 1'h1);
        wr(8'h40, 1'h1);
        wr(8'h55, 1'h1);
        stop();
        repeat (20) @(negedge clk_in);
        check("protbusy", {8'h00, busy}, 9'h000);
        wp = 1'h0;
        rdat(16'h0A40, 8'hC3);
        $display("test_protect done");
    endtask : test_protect
    task automatic test_chip_select();
        for (int i = 0; i < 8; i++)
        begin
            cs = i[2:0];
            repeat (4) @(negedge clk_in);
            sel({DT, i[2:0], 1'h0}, 1'h1);
            stop();
            sel({DT, ~i[2:0], 1'h0}, 1'h0);
            stop();
        end
        sel({~DT, 3'h7, 1'h0}, 1'h0);
        stop();
        cs = 3'h0;
        $display("test_chip_select done");
    endtask : test_chip_select
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // main sequence after six reset cycles
    initial
    begin
        repeat (6) @(negedge clk_in);
        reset_n_in = 1'h1;
        test_reset();
        test_page_write();
        test_protect();
        test_chip_select();
        final_report();
    end
    // watchdog, well past the expected run
    initial
    begin
        #1500000;
        failures++;
        final_report();
    end
endmodule : test_two_wire_serial_eeprom_slave
